/* logic/bpbu_alu.sv */
// combinational bit operations, branch conditions and destination forming
// assumes the core holds operands stable through its execute cycle
module bpbu_alu (
	bpbu_alu_if.alu bus
);
	always_comb begin
		bus.carry_out = bus.carry;
		bus.bit_out = bus.bitval;
		bus.take = 1'b0;
		bus.target = bus.pc + {{8{bus.rel[7]}}, bus.rel};
		case (bus.op)
			bpbu_pkg::OP_AND_C: bus.carry_out = bus.carry & bus.bitval;
			bpbu_pkg::OP_ANDN_C: bus.carry_out = bus.carry & ~bus.bitval;
			bpbu_pkg::OP_OR_C: bus.carry_out = bus.carry | bus.bitval;
			bpbu_pkg::OP_ORN_C: bus.carry_out = bus.carry | ~bus.bitval;
			bpbu_pkg::OP_MOV_CB: bus.carry_out = bus.bitval;
			bpbu_pkg::OP_MOV_BC: bus.bit_out = bus.carry;
			bpbu_pkg::OP_CLR_C: bus.carry_out = 1'b0;
			bpbu_pkg::OP_CLR_B: bus.bit_out = 1'b0;
			bpbu_pkg::OP_SET_C: bus.carry_out = 1'b1;
			bpbu_pkg::OP_SET_B: bus.bit_out = 1'b1;
			bpbu_pkg::OP_INV_C: bus.carry_out = ~bus.carry;
			bpbu_pkg::OP_INV_B: bus.bit_out = ~bus.bitval;
			bpbu_pkg::OP_JMP_C1: bus.take = bus.carry;
			bpbu_pkg::OP_JMP_C0: bus.take = ~bus.carry;
			bpbu_pkg::OP_JMP_B1: bus.take = bus.bitval;
			bpbu_pkg::OP_JMP_B0: bus.take = ~bus.bitval;
			bpbu_pkg::OP_JMP_TC: begin
				bus.take = bus.bitval;
				bus.bit_out = 1'b0;
			end
			bpbu_pkg::OP_JMP_SHORT: bus.take = 1'b1;
			bpbu_pkg::OP_JMP_LONG, bpbu_pkg::OP_CALL_LONG: begin
				bus.take = 1'b1;
				bus.target = {bus.b1, bus.rel};
			end
			bpbu_pkg::OP_JMP_PAGE, bpbu_pkg::OP_CALL_PAGE: begin
				bus.take = 1'b1;
				bus.target = {bus.pc[15:11], bus.opcode[7:5], bus.b1};
			end
			bpbu_pkg::OP_JMP_IDX: begin
				bus.take = 1'b1;
				bus.target = bus.data_pointer + {8'h00, bus.acc};
			end
			bpbu_pkg::OP_JMP_AZ: bus.take = (bus.acc == 8'h00);
			bpbu_pkg::OP_JMP_ANZ: bus.take = (bus.acc != 8'h00);
			bpbu_pkg::OP_DEC_BR: bus.take = ((bus.operand - 8'h01) != 8'h00);
			bpbu_pkg::OP_CMP_IMM, bpbu_pkg::OP_CMP_DIR: begin
				bus.take = (bus.operand != bus.cmp);
				bus.carry_out = (bus.operand < bus.cmp);
			end
			default: bus.take = 1'b0;
		endcase
	end
endmodule : bpbu_alu

/* logic/bpbu_alu_if.sv */
// operands and results passed between the core and the bit/branch alu
// assumes bpbu_pkg is compiled first
interface bpbu_alu_if;
	bpbu_pkg::bpbu_op_t op;
	logic [7:0] opcode;
	logic carry;
	logic bitval;
	logic [7:0] acc;
	logic [7:0] operand;
	logic [7:0] cmp;
	logic [7:0] b1;
	logic [7:0] rel;
	logic [15:0] pc;
	logic [15:0] data_pointer;
	logic carry_out;
	logic bit_out;
	logic take;
	logic [15:0] target;
	modport core (output op, opcode, carry, bitval, acc, operand, cmp, b1, rel, pc, data_pointer,
		input carry_out, bit_out, take, target);
	modport alu (input op, opcode, carry, bitval, acc, operand, cmp, b1, rel, pc, data_pointer,
		output carry_out, bit_out, take, target);
endinterface : bpbu_alu_if

/* logic/bpbu_core.sv */
// bit processor and program flow core with internal ram and bit sfrs
// assumes code memory answers a read one cycle after code_rd is high
`include "bpbu_regs.svh"
module bpbu_core (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] code_data,
	input wire logic interrupt_active,
	output logic [15:0] code_addr,
	output logic code_rd,
	output logic [15:0] program_counter,
	output logic interrupt_done,
	output logic [7:0] port0,
	output logic [7:0] port1,
	output logic [7:0] port2,
	output logic [7:0] port3
);
	bpbu_pkg::bpbu_state_t state;
	bpbu_pkg::bpbu_state_t next_state;
	logic [15:0] next_program_counter;
	logic [15:0] next_code_addr;
	logic next_code_rd;
	logic next_interrupt_done;
	logic [7:0] opcode;
	logic [7:0] next_opcode;
	logic [7:0] b1;
	logic [7:0] next_b1;
	logic [7:0] b2;
	logic [7:0] next_b2;
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic [1:0] cur_len;
	logic [15:0] data_pointer;
	logic [15:0] next_data_pointer;
	logic [7:0] sp;
	logic [7:0] next_sp;
	logic [7:0] iram [128];
	logic [7:0] sfr [16];
	logic [1:0] we;
	logic [7:0] wa [2];
	logic [7:0] wd [2];
	bpbu_pkg::bpbu_op_t op_cap;
	bpbu_pkg::bpbu_op_t op_cur;
	logic [7:0] acc;
	logic [7:0] status_word;
	logic carry;
	logic [7:0] bit_addr;
	logic [7:0] bit_byte_val;
	logic bitval;
	logic [7:0] dir_val;
	logic [7:0] merged;
	bpbu_alu_if alu_bus ();

	function automatic bpbu_pkg::bpbu_op_t decode(input logic [7:0] opc);
		decode = bpbu_pkg::OP_NOP;
		if (opc[4:0] == `BPBU_OPC_PAGE_JMP) decode = bpbu_pkg::OP_JMP_PAGE;
		else if (opc[4:0] == `BPBU_OPC_PAGE_CALL) decode = bpbu_pkg::OP_CALL_PAGE;
		else begin
			case (opc)
				`BPBU_OPC_AND_C: decode = bpbu_pkg::OP_AND_C;
				`BPBU_OPC_ANDN_C: decode = bpbu_pkg::OP_ANDN_C;
				`BPBU_OPC_OR_C: decode = bpbu_pkg::OP_OR_C;
				`BPBU_OPC_ORN_C: decode = bpbu_pkg::OP_ORN_C;
				`BPBU_OPC_MOV_CB: decode = bpbu_pkg::OP_MOV_CB;
				`BPBU_OPC_MOV_BC: decode = bpbu_pkg::OP_MOV_BC;
				`BPBU_OPC_CLR_C: decode = bpbu_pkg::OP_CLR_C;
				`BPBU_OPC_CLR_B: decode = bpbu_pkg::OP_CLR_B;
				`BPBU_OPC_SET_C: decode = bpbu_pkg::OP_SET_C;
				`BPBU_OPC_SET_B: decode = bpbu_pkg::OP_SET_B;
				`BPBU_OPC_INV_C: decode = bpbu_pkg::OP_INV_C;
				`BPBU_OPC_INV_B: decode = bpbu_pkg::OP_INV_B;
				`BPBU_OPC_JMP_C1: decode = bpbu_pkg::OP_JMP_C1;
				`BPBU_OPC_JMP_C0: decode = bpbu_pkg::OP_JMP_C0;
				`BPBU_OPC_JMP_B1: decode = bpbu_pkg::OP_JMP_B1;
				`BPBU_OPC_JMP_B0: decode = bpbu_pkg::OP_JMP_B0;
				`BPBU_OPC_JMP_TC: decode = bpbu_pkg::OP_JMP_TC;
				`BPBU_OPC_JMP_SHORT: decode = bpbu_pkg::OP_JMP_SHORT;
				`BPBU_OPC_JMP_LONG: decode = bpbu_pkg::OP_JMP_LONG;
				`BPBU_OPC_CALL_LONG: decode = bpbu_pkg::OP_CALL_LONG;
				`BPBU_OPC_JMP_IDX: decode = bpbu_pkg::OP_JMP_IDX;
				`BPBU_OPC_SUB_EXIT: decode = bpbu_pkg::OP_SUB_EXIT;
				`BPBU_OPC_INT_EXIT: decode = bpbu_pkg::OP_INT_EXIT;
				`BPBU_OPC_JMP_AZ: decode = bpbu_pkg::OP_JMP_AZ;
				`BPBU_OPC_JMP_ANZ: decode = bpbu_pkg::OP_JMP_ANZ;
				`BPBU_OPC_DEC_BR: decode = bpbu_pkg::OP_DEC_BR;
				`BPBU_OPC_CMP_IMM: decode = bpbu_pkg::OP_CMP_IMM;
				`BPBU_OPC_CMP_DIR: decode = bpbu_pkg::OP_CMP_DIR;
				`BPBU_OPC_CODE_DP: decode = bpbu_pkg::OP_CODE_DP;
				`BPBU_OPC_CODE_PC: decode = bpbu_pkg::OP_CODE_PC;
				`BPBU_OPC_LD_DP: decode = bpbu_pkg::OP_LD_DP;
				`BPBU_OPC_LD_ACC: decode = bpbu_pkg::OP_LD_ACC;
				`BPBU_OPC_LD_DIR: decode = bpbu_pkg::OP_LD_DIR;
				default: decode = bpbu_pkg::OP_NOP;
			endcase
		end
	endfunction : decode

	// instruction length in bytes
	function automatic logic [1:0] op_len(input bpbu_pkg::bpbu_op_t o);
		case (o)
			bpbu_pkg::OP_JMP_B1, bpbu_pkg::OP_JMP_B0, bpbu_pkg::OP_JMP_TC,
			bpbu_pkg::OP_JMP_LONG, bpbu_pkg::OP_CALL_LONG, bpbu_pkg::OP_DEC_BR,
			bpbu_pkg::OP_CMP_IMM, bpbu_pkg::OP_CMP_DIR, bpbu_pkg::OP_LD_DP,
			bpbu_pkg::OP_LD_DIR: op_len = 2'h3;
			bpbu_pkg::OP_NOP, bpbu_pkg::OP_CLR_C, bpbu_pkg::OP_SET_C, bpbu_pkg::OP_INV_C,
			bpbu_pkg::OP_JMP_IDX, bpbu_pkg::OP_SUB_EXIT, bpbu_pkg::OP_INT_EXIT,
			bpbu_pkg::OP_CODE_DP, bpbu_pkg::OP_CODE_PC: op_len = 2'h1;
			default: op_len = 2'h2;
		endcase
	endfunction : op_len

	function automatic logic [7:0] bit_byte(input logic [7:0] ba);
		if (ba[7]) bit_byte = {ba[7:3], 3'h0};
		else bit_byte = `BPBU_BIT_PAGE + {4'h0, ba[6:3]};
	endfunction : bit_byte

	function automatic logic [7:0] rd_byte(input logic [7:0] a);
		if (!a[7]) rd_byte = iram[a[6:0]];
		else if (a[2:0] == 3'h0) rd_byte = sfr[a[6:3]];
		else rd_byte = `BPBU_REG_RST;
	endfunction : rd_byte

	assign op_cap = decode(code_data);
	assign op_cur = decode(opcode);
	assign acc = sfr[`BPBU_IDX_ACC];
	assign status_word = sfr[`BPBU_IDX_STATUS];
	assign carry = status_word[`BPBU_CY_BIT];
	always_comb begin
		bit_addr = bit_byte(b1);
		bit_byte_val = rd_byte(bit_addr);
		bitval = bit_byte_val[b1[2:0]];
		dir_val = rd_byte(b1);
	end
	assign port0 = sfr[`BPBU_IDX_P0];
	assign port1 = sfr[`BPBU_IDX_P1];
	assign port2 = sfr[`BPBU_IDX_P2];
	assign port3 = sfr[`BPBU_IDX_P3];

	assign alu_bus.op = op_cur;
	assign alu_bus.opcode = opcode;
	assign alu_bus.carry = carry;
	assign alu_bus.bitval = bitval;
	assign alu_bus.acc = acc;
	assign alu_bus.operand = (op_cur == bpbu_pkg::OP_DEC_BR) ? dir_val : acc;
	assign alu_bus.cmp = (op_cur == bpbu_pkg::OP_CMP_IMM) ? b1 : dir_val;
	assign alu_bus.b1 = b1;
	assign alu_bus.rel = (op_len(op_cur) == `BPBU_LEN_LONG) ? b2 : b1;
	assign alu_bus.pc = program_counter;
	assign alu_bus.data_pointer = data_pointer;

	bpbu_alu u_alu (
		.bus(alu_bus)
	);

	always_comb begin
		next_state = state;
		next_program_counter = program_counter;
		next_code_addr = code_addr;
		next_code_rd = 1'b0;
		next_interrupt_done = 1'b0;
		next_opcode = opcode;
		next_b1 = b1;
		next_b2 = b2;
		next_cnt = cnt;
		next_data_pointer = data_pointer;
		next_sp = sp;
		we = 2'h0;
		wa[0] = b1;
		wa[1] = b1;
		wd[0] = `BPBU_REG_RST;
		wd[1] = `BPBU_REG_RST;
		merged = bit_byte_val;
		merged[b1[2:0]] = alu_bus.bit_out;
		cur_len = (cnt == 2'h0) ? op_len(op_cap) : op_len(op_cur);
		unique case (state)
			bpbu_pkg::S_REQ: begin
				next_code_addr = program_counter;
				next_code_rd = 1'b1;
				next_program_counter = program_counter + 16'h0001;
				next_state = bpbu_pkg::S_LAT;
			end
			bpbu_pkg::S_LAT: next_state = bpbu_pkg::S_CAP;
			bpbu_pkg::S_CAP: begin
				if (cnt == 2'h0) next_opcode = code_data;
				else if (cnt == 2'h1) next_b1 = code_data;
				else next_b2 = code_data;
				if (2'(cnt + 2'h1) < cur_len) begin
					next_cnt = 2'(cnt + 2'h1);
					next_code_addr = program_counter;
					next_code_rd = 1'b1;
					next_program_counter = program_counter + 16'h0001;
					next_state = bpbu_pkg::S_LAT;
				end else begin
					next_cnt = 2'h0;
					next_state = bpbu_pkg::S_EXEC;
				end
			end
			bpbu_pkg::S_EXEC: begin
				next_state = bpbu_pkg::S_REQ;
				if (alu_bus.take) next_program_counter = alu_bus.target;
				case (op_cur)
					bpbu_pkg::OP_MOV_BC, bpbu_pkg::OP_CLR_B, bpbu_pkg::OP_SET_B,
					bpbu_pkg::OP_INV_B, bpbu_pkg::OP_JMP_TC: begin
						we[0] = 1'b1;
						wa[0] = bit_addr;
						wd[0] = merged;
					end
					bpbu_pkg::OP_AND_C, bpbu_pkg::OP_ANDN_C, bpbu_pkg::OP_OR_C,
					bpbu_pkg::OP_ORN_C, bpbu_pkg::OP_MOV_CB, bpbu_pkg::OP_CLR_C,
					bpbu_pkg::OP_SET_C, bpbu_pkg::OP_INV_C, bpbu_pkg::OP_CMP_IMM,
					bpbu_pkg::OP_CMP_DIR: begin
						we[0] = 1'b1;
						wa[0] = `BPBU_ADDR_STATUS;
						wd[0] = status_word;
						wd[0][`BPBU_CY_BIT] = alu_bus.carry_out;
					end
					bpbu_pkg::OP_DEC_BR: begin
						we[0] = 1'b1;
						wd[0] = dir_val - 8'h01;
					end
					bpbu_pkg::OP_CALL_LONG, bpbu_pkg::OP_CALL_PAGE: begin
						we = 2'h3;
						wa[0] = {1'b0, 7'(sp[6:0] + 7'h01)};
						wd[0] = program_counter[7:0];
						wa[1] = {1'b0, 7'(sp[6:0] + 7'h02)};
						wd[1] = program_counter[15:8];
						next_sp = sp + 8'h02;
					end
					bpbu_pkg::OP_SUB_EXIT, bpbu_pkg::OP_INT_EXIT: begin
						next_program_counter = {iram[sp[6:0]], iram[7'(sp[6:0] - 7'h01)]};
						next_sp = sp - 8'h02;
						next_interrupt_done = (op_cur == bpbu_pkg::OP_INT_EXIT) &&
							interrupt_active;
					end
					bpbu_pkg::OP_CODE_DP, bpbu_pkg::OP_CODE_PC: begin
						next_code_rd = 1'b1;
						next_code_addr = ((op_cur == bpbu_pkg::OP_CODE_DP) ? data_pointer
							: program_counter) + {8'h00, acc};
						next_state = bpbu_pkg::S_TLAT;
					end
					bpbu_pkg::OP_LD_DP: next_data_pointer = {b1, b2};
					bpbu_pkg::OP_LD_ACC: begin
						we[0] = 1'b1;
						wa[0] = `BPBU_ADDR_ACC;
						wd[0] = b1;
					end
					bpbu_pkg::OP_LD_DIR: begin
						we[0] = 1'b1;
						wd[0] = b2;
					end
					default: next_sp = sp;
				endcase
			end
			bpbu_pkg::S_TLAT: next_state = bpbu_pkg::S_TCAP;
			bpbu_pkg::S_TCAP: begin
				we[0] = 1'b1;
				wa[0] = `BPBU_ADDR_ACC;
				wd[0] = code_data;
				next_state = bpbu_pkg::S_REQ;
			end
			default: next_state = bpbu_pkg::S_REQ;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= bpbu_pkg::S_REQ;
			program_counter <= `BPBU_PC_RST;
			code_addr <= `BPBU_PC_RST;
			code_rd <= 1'b0;
			interrupt_done <= 1'b0;
			opcode <= `BPBU_REG_RST;
			b1 <= `BPBU_REG_RST;
			b2 <= `BPBU_REG_RST;
			cnt <= 2'h0;
			data_pointer <= `BPBU_PC_RST;
			sp <= `BPBU_SP_RST;
			for (int i = 0; i < 128; i++) iram[i] <= `BPBU_REG_RST;
			for (int i = 0; i < 16; i++) sfr[i] <= `BPBU_REG_RST;
			sfr[`BPBU_IDX_P0] <= `BPBU_PORT_RST;
			sfr[`BPBU_IDX_P1] <= `BPBU_PORT_RST;
			sfr[`BPBU_IDX_P2] <= `BPBU_PORT_RST;
			sfr[`BPBU_IDX_P3] <= `BPBU_PORT_RST;
		end else begin
			state <= next_state;
			program_counter <= next_program_counter;
			code_addr <= next_code_addr;
			code_rd <= next_code_rd;
			interrupt_done <= next_interrupt_done;
			opcode <= next_opcode;
			b1 <= next_b1;
			b2 <= next_b2;
			cnt <= next_cnt;
			data_pointer <= next_data_pointer;
			sp <= next_sp;
			for (int i = 0; i < 2; i++) begin
				if (we[i] && !wa[i][7]) iram[wa[i][6:0]] <= wd[i];
				else if (we[i] && wa[i][2:0] == 3'h0) sfr[wa[i][6:3]] <= wd[i];
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence exec_op(bpbu_pkg::bpbu_op_t o);
		state == bpbu_pkg::S_EXEC && op_cur == o;
	endsequence
	sequence table_fill;
		code_rd ##2 (acc == $past(code_data));
	endsequence

	short_jump_a: assert property (exec_op(bpbu_pkg::OP_JMP_SHORT) |=>
		program_counter == $past(program_counter) + {{8{$past(b1[7])}}, $past(b1)})
		else $error("short jump target wrong");
	long_jump_a: assert property (exec_op(bpbu_pkg::OP_JMP_LONG) |=>
		program_counter == {$past(b1), $past(b2)})
		else $error("long jump target wrong");
	page_jump_a: assert property (exec_op(bpbu_pkg::OP_JMP_PAGE) |=>
		program_counter == {$past(program_counter[15:11]), $past(opcode[7:5]), $past(b1)})
		else $error("page jump target wrong");
	idx_jump_a: assert property (exec_op(bpbu_pkg::OP_JMP_IDX) |=>
		program_counter == $past(data_pointer) + {8'h00, $past(acc)})
		else $error("computed jump target wrong");
	table_read_a: assert property (exec_op(bpbu_pkg::OP_CODE_DP) |=> table_fill)
		else $error("table read did not load acc");
	call_push_a: assert property (exec_op(bpbu_pkg::OP_CALL_LONG) |=>
		sp == $past(sp) + 8'h02 && iram[sp[6:0]] == $past(program_counter[15:8]))
		else $error("call did not push return address");
	exit_resume_a: assert property (exec_op(bpbu_pkg::OP_SUB_EXIT) |=>
		program_counter == {$past(iram[sp[6:0]]), $past(iram[7'(sp[6:0] - 7'h01)])})
		else $error("exit did not resume after call");
	int_done_a: assert property (exec_op(bpbu_pkg::OP_INT_EXIT) |=>
		interrupt_done == $past(interrupt_active) ##1 !interrupt_done)
		else $error("interrupt end signal wrong");
	carry_and_a: assert property (exec_op(bpbu_pkg::OP_AND_C) |=>
		carry == ($past(carry) & $past(bitval)))
		else $error("carry and result wrong");
	test_clear_a: assert property (exec_op(bpbu_pkg::OP_JMP_TC) ##0 bitval |=>
		(rd_byte($past(bit_addr)) & (8'h01 << $past(b1[2:0]))) == 8'h00)
		else $error("test and clear left bit set");
	dec_branch_a: assert property (exec_op(bpbu_pkg::OP_DEC_BR) |=>
		rd_byte($past(b1)) == $past(dir_val) - 8'h01)
		else $error("decrement not stored");
	cmp_carry_a: assert property (exec_op(bpbu_pkg::OP_CMP_IMM) |=>
		carry == ($past(acc) < $past(b1)))
		else $error("compare carry wrong");
	port_bit_a: assert property (exec_op(bpbu_pkg::OP_SET_B) ##0 (b1[7] &&
		b1[6:3] == `BPBU_IDX_P1) |=> port1 == ($past(port1) | (8'h01 << $past(b1[2:0]))))
		else $error("port bit set disturbed lines");
endmodule : bpbu_core

/* logic/bpbu_pkg.sv */
// types shared by the core and its bit/branch alu
// assumes nothing beyond a SystemVerilog compiler
package bpbu_pkg;
	typedef enum logic [2:0] {
		S_REQ = 3'b000,
		S_LAT = 3'b001,
		S_CAP = 3'b010,
		S_EXEC = 3'b011,
		S_TLAT = 3'b100,
		S_TCAP = 3'b101
	} bpbu_state_t;
	typedef enum logic [5:0] {
		OP_NOP, OP_AND_C, OP_ANDN_C, OP_OR_C, OP_ORN_C, OP_MOV_CB, OP_MOV_BC,
		OP_CLR_C, OP_CLR_B, OP_SET_C, OP_SET_B, OP_INV_C, OP_INV_B,
		OP_JMP_C1, OP_JMP_C0, OP_JMP_B1, OP_JMP_B0, OP_JMP_TC,
		OP_JMP_SHORT, OP_JMP_LONG, OP_JMP_PAGE, OP_CALL_LONG, OP_CALL_PAGE,
		OP_JMP_IDX, OP_SUB_EXIT, OP_INT_EXIT, OP_JMP_AZ, OP_JMP_ANZ,
		OP_DEC_BR, OP_CMP_IMM, OP_CMP_DIR, OP_CODE_DP, OP_CODE_PC,
		OP_LD_DP, OP_LD_ACC, OP_LD_DIR
	} bpbu_op_t;
endpackage : bpbu_pkg

/* logic/bpbu_regs.svh */
// constants for the bit processor and branch unit
// assumes a core that fetches code bytes over a one-latency read port
`ifndef BPBU_REGS_SVH
`define BPBU_REGS_SVH
`define BPBU_BIT_PAGE 8'h20
`define BPBU_IDX_P0 4'h0
`define BPBU_IDX_P1 4'h2
`define BPBU_IDX_P2 4'h4
`define BPBU_IDX_P3 4'h6
`define BPBU_IDX_STATUS 4'hA
`define BPBU_IDX_ACC 4'hC
`define BPBU_ADDR_STATUS 8'hD0
`define BPBU_ADDR_ACC 8'hE0
`define BPBU_CY_BIT 7
`define BPBU_REG_RST 8'h00
`define BPBU_PORT_RST 8'hFF
`define BPBU_SP_RST 8'h07
`define BPBU_PC_RST 16'h0000
`define BPBU_LEN_LONG 2'h3
`define BPBU_OPC_PAGE_JMP 5'h01
`define BPBU_OPC_PAGE_CALL 5'h11
`define BPBU_OPC_AND_C 8'h82
`define BPBU_OPC_ANDN_C 8'hB0
`define BPBU_OPC_OR_C 8'h72
`define BPBU_OPC_ORN_C 8'hA0
`define BPBU_OPC_MOV_CB 8'hA2
`define BPBU_OPC_MOV_BC 8'h92
`define BPBU_OPC_CLR_C 8'hC3
`define BPBU_OPC_CLR_B 8'hC2
`define BPBU_OPC_SET_C 8'hD3
`define BPBU_OPC_SET_B 8'hD2
`define BPBU_OPC_INV_C 8'hB3
`define BPBU_OPC_INV_B 8'hB2
`define BPBU_OPC_JMP_C1 8'h40
`define BPBU_OPC_JMP_C0 8'h50
`define BPBU_OPC_JMP_B1 8'h20
`define BPBU_OPC_JMP_B0 8'h30
`define BPBU_OPC_JMP_TC 8'h10
`define BPBU_OPC_JMP_SHORT 8'h80
`define BPBU_OPC_JMP_LONG 8'h02
`define BPBU_OPC_CALL_LONG 8'h12
`define BPBU_OPC_JMP_IDX 8'h73
`define BPBU_OPC_SUB_EXIT 8'h22
`define BPBU_OPC_INT_EXIT 8'h32
`define BPBU_OPC_JMP_AZ 8'h60
`define BPBU_OPC_JMP_ANZ 8'h70
`define BPBU_OPC_DEC_BR 8'hD5
`define BPBU_OPC_CMP_IMM 8'hB4
`define BPBU_OPC_CMP_DIR 8'hB5
`define BPBU_OPC_CODE_DP 8'h93
`define BPBU_OPC_CODE_PC 8'h83
`define BPBU_OPC_LD_DP 8'h90
`define BPBU_OPC_LD_ACC 8'h74
`define BPBU_OPC_LD_DIR 8'h75
`endif

/* tb/bpbu_code_mem.sv */
// program memory model for the bit and branch core
// assumes the bench loads mem while the core is held in reset
module bpbu_code_mem (
	input wire logic clk,
	input wire logic code_rd,
	input wire logic [15:0] code_addr,
	output logic [7:0] code_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;
	logic hit = 1'b0;
	// answer one cycle after the request, inverted last byte otherwise
	always @(posedge clk) begin
		hit <= code_rd;
		if (code_rd) begin
			last <= mem[code_addr];
		end
	end
	assign code_data = hit ? last : ~last;
endmodule : bpbu_code_mem

/* tb/testbench.sv */
// self-checking bench: runs small programs and judges ports and fetches
// assumes bpbu_core fetches on its own after reset
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic interrupt_active = 1'b0;
	logic [7:0] code_data;
	logic [15:0] code_addr;
	logic [15:0] program_counter;
	logic code_rd;
	logic interrupt_done;
	logic [7:0] port0;
	logic [7:0] port1;
	logic [7:0] port2;
	logic [7:0] port3;
	int n_mismatch = 0;
	int total_checks = 0;
	int n_done = 0;
	initial forever #4 clk = ~clk;
	bpbu_core u_bpbu_core (.clk(clk), .reset(reset), .code_data(code_data),
		.interrupt_active(interrupt_active), .code_addr(code_addr), .code_rd(code_rd),
		.program_counter(program_counter), .interrupt_done(interrupt_done),
		.port0(port0), .port1(port1), .port2(port2), .port3(port3));
	bpbu_code_mem u_bpbu_code_mem (.clk(clk), .code_rd(code_rd), .code_addr(code_addr),
		.code_data(code_data));
	always @(posedge clk) begin
		if (reset) begin
			n_done = 0;
		end else if (interrupt_done === 1'b1) begin
			n_done++;
		end
	end
	task automatic tally_and_finish;
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic prep(input logic irq);
		@(posedge clk);
		reset <= 1'b1;
		interrupt_active <= irq;
		for (int i = 0; i < 65536; i++) begin
			u_bpbu_code_mem.mem[i] = 8'h00;
		end
	endtask : prep
	task automatic put(input logic [15:0] a, input logic [7:0] b []);
		for (int i = 0; i < b.size(); i++) begin
			u_bpbu_code_mem.mem[a + 16'(i)] = b[i];
		end
	endtask : put
	task automatic go;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
	endtask : go
	task automatic wait_fetch(input logic [15:0] a);
		int i;
		for (i = 0; i < 3000; i++) begin
			@(negedge clk);
			if (code_rd === 1'b1 && code_addr === a) break;
		end
		chk(16'(code_rd === 1'b1 && code_addr === a), 16'h0001);
		if (i == 3000) begin
			tally_and_finish();
		end
	endtask : wait_fetch
	task automatic t_bits;
		prep(1'b0);
		put(16'h0000, '{8'h75, 8'h90, 8'h00, 8'hD2, 8'h00, 8'hA2, 8'h00, 8'h92, 8'h90,
			8'hB0, 8'h00, 8'h92, 8'h91, 8'hA0, 8'h7F, 8'h92, 8'h92, 8'h82, 8'h7F,
			8'h72, 8'h00, 8'h92, 8'h93, 8'hB3, 8'h92, 8'h94, 8'hB2, 8'h95, 8'hD2,
			8'h97, 8'hC3, 8'hD2, 8'hD7, 8'h92, 8'h96, 8'hC2, 8'hB7, 8'h80, 8'hFE});
		go();
		wait_fetch(16'h0025);
		chk(16'(port1), 16'h00ED);
		chk(16'(port3), 16'h007F);
		chk(16'(port0), 16'h00FF);
		chk(16'(port2), 16'h00FF);
	endtask : t_bits
	task automatic t_cond;
		prep(1'b0);
		put(16'h0000, '{8'h75, 8'h80, 8'h00, 8'h75, 8'hA0, 8'h00, 8'hD3, 8'h40, 8'h02,
			8'hD2, 8'h80, 8'h50, 8'h02, 8'hD2, 8'h81, 8'hD2, 8'hD0, 8'h20, 8'hD0,
			8'h02, 8'hD2, 8'h82, 8'h30, 8'hD0, 8'h02, 8'hD2, 8'h83, 8'h10, 8'hD0,
			8'h02, 8'hD2, 8'h84, 8'h10, 8'hD0, 8'h02, 8'hD2, 8'h85, 8'h74, 8'h00,
			8'h60, 8'h02, 8'hD2, 8'h86, 8'h70, 8'h02, 8'hD2, 8'h87, 8'h75, 8'h30,
			8'h02, 8'hD5, 8'h30, 8'h02, 8'hD2, 8'hA0, 8'hD5, 8'h30, 8'h02, 8'hD2,
			8'hA1, 8'hB4, 8'h05, 8'h02, 8'hD2, 8'hA2, 8'h92, 8'hA3, 8'hB4, 8'h00,
			8'h02, 8'hD2, 8'hA4, 8'h92, 8'hA5, 8'h74, 8'h09, 8'hB5, 8'h30, 8'h02,
			8'hD2, 8'hA6, 8'h92, 8'hA7, 8'h80, 8'hFE});
		go();
		wait_fetch(16'h0053);
		chk(16'(port0), 16'h00AA);
		chk(16'(port2), 16'h001A);
	endtask : t_cond
	task automatic t_jumps;
		prep(1'b0);
		put(16'h0000, '{8'h75, 8'h80, 8'h00, 8'h02, 8'h01, 8'h00});
		put(16'h0100, '{8'h80, 8'h7F, 8'h00, 8'hE1, 8'hF0});
		put(16'h0181, '{8'h80, 8'h80});
		put(16'h07F0, '{8'h12, 8'h12, 8'h34, 8'hB4, 8'h5A, 8'h02, 8'hD2, 8'h80, 8'h90,
			8'h20, 8'h00, 8'h74, 8'h03, 8'h93, 8'hB4, 8'hA5, 8'h02, 8'hD2, 8'h81,
			8'h91, 8'h00, 8'hD2, 8'h82, 8'h74, 8'h04, 8'h90, 8'h30, 8'h00, 8'h73});
		put(16'h0C00, '{8'h32});
		put(16'h1234, '{8'h74, 8'h02, 8'h83, 8'h22, 8'h00, 8'h5A});
		put(16'h2003, '{8'hA5});
		put(16'h3004, '{8'hD2, 8'h83, 8'h80, 8'hFE});
		go();
		wait_fetch(16'h0100);
		wait_fetch(16'h0181);
		wait_fetch(16'h0103);
		wait_fetch(16'h07F0);
		wait_fetch(16'h1234);
		wait_fetch(16'h1239);
		wait_fetch(16'h07F3);
		wait_fetch(16'h2003);
		wait_fetch(16'h0C00);
		wait_fetch(16'h0805);
		wait_fetch(16'h3004);
		wait_fetch(16'h3006);
		chk(program_counter, 16'h3007);
		chk(16'(port0), 16'h000F);
		chk(16'(n_done), 16'h0000);
	endtask : t_jumps
	task automatic t_interrupt_exit;
		prep(1'b1);
		put(16'h0000, '{8'h12, 8'h00, 8'h10, 8'h80, 8'hFE});
		put(16'h0010, '{8'h32});
		go();
		wait_fetch(16'h0010);
		wait_fetch(16'h0003);
		repeat (4) @(negedge clk);
		chk(16'(n_done), 16'h0001);
	endtask : t_interrupt_exit
	initial begin
		t_bits();
		t_cond();
		t_jumps();
		t_interrupt_exit();
		tally_and_finish();
	end
endmodule : testbench
